/* File: inc/panel_pkg.sv */
/*
 * Shared constants and types for the panel video input and reset handler.
 * Assumes a 250 MHz core clock; all times are turned into cycle counts here.
 */
package panel_pkg;
    localparam int CORE_CLK_MHZ = 250;
    // Reset pin filter times
    localparam int SPIKE_REJECT_US = 5;
    localparam int RESET_SURE_US = 9;
    localparam int SPIKE_REJECT_CYC = SPIKE_REJECT_US * CORE_CLK_MHZ;
    localparam int RESET_SURE_CYC = RESET_SURE_US * CORE_CLK_MHZ;
    // Reset-cancel limits
    localparam int CANCEL_SLEEP_MS = 5;
    localparam int CANCEL_AWAKE_MS = 120;
    localparam int CANCEL_SLEEP_CYC = CANCEL_SLEEP_MS * 1000 * CORE_CLK_MHZ;
    localparam int CANCEL_AWAKE_CYC = CANCEL_AWAKE_MS * 1000 * CORE_CLK_MHZ;
    // Sync, release filter and output stages spent before cancel counting
    localparam int CANCEL_LAG_CYC = 6;
    // Settings reload from nonvolatile storage
    localparam int RELOAD_WORDS = 4;
    localparam logic [7:0] ID_BYTE_RESET = 8'h00;
    localparam logic [7:0] COMMON_VOLTAGE_SETTING_RESET = 8'h00;
    // Pixel bus formats
    localparam int PIXEL_BUS_W = 24;
    localparam logic [1:0] FMT_24 = 2'h0;
    localparam logic [1:0] FMT_18 = 2'h1;
    localparam logic [1:0] FMT_16 = 2'h2;
    localparam int LINE_CNT_W = 10;
    localparam int PIX_CNT_W = 10;
    typedef enum {
        RST_IDLE, RST_PENDING, RST_ACTIVE, RST_CANCEL
    } reset_state_type;
endpackage

/* File: inc/pixel_if.sv */
/*
 * Carrier between the top module and the pixel capture block.
 * Assumes both ends run on the core clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface pixel_if;
    logic pclk_rise;
    logic hsync;
    logic vsync;
    logic qualifier;
    logic [23:0] data;
    logic [1:0] fmt;
    logic blank;
    logic word_valid;
    logic [23:0] word;
    logic [9:0] col;
    logic [9:0] row;
    modport top (output pclk_rise, hsync, vsync, qualifier, data, fmt,
        blank, input word_valid, word, col, row);
    modport cap (input pclk_rise, hsync, vsync, qualifier, data, fmt,
        blank, output word_valid, word, col, row);
endinterface
`default_nettype wire

/* File: src/pixel_capture.sv */
/*
 * Captures pixel words on sampled pixel clock rises while the qualifier is
 * high, and tracks column and row from the syncs.
 * Assumes all inputs are already synchronised to the core clock.
 */
`timescale 1ns/1ps
`default_nettype none
module pixel_capture
    import panel_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Pixel side
    pixel_if.cap px
);
    logic hs_prev_q;
    logic vs_prev_q;
    logic [23:0] expanded;
    wire hs_fall = px.pclk_rise && hs_prev_q && !px.hsync;
    wire vs_fall = px.pclk_rise && vs_prev_q && !px.vsync;
    wire take = px.pclk_rise && px.qualifier && !px.blank;

    // Narrow formats are widened by repeating the top bits of each colour
    always_comb begin
        expanded = px.data;
        if (px.fmt == FMT_18) begin
            expanded = {px.data[17:12], px.data[17:16], px.data[11:6],
                px.data[11:10], px.data[5:0], px.data[5:4]};
        end else if (px.fmt == FMT_16) begin
            expanded = {px.data[15:11], px.data[15:13], px.data[10:5],
                px.data[10:9], px.data[4:0], px.data[4:2]};
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hs_prev_q <= 1'b1;
            vs_prev_q <= 1'b1;
            px.word_valid <= 1'b0;
            px.word <= 24'h000000;
            px.col <= 10'h000;
            px.row <= 10'h000;
        end else begin
            if (px.pclk_rise) begin
                hs_prev_q <= px.hsync;
                vs_prev_q <= px.vsync;
            end
            px.word_valid <= take;
            if (take) begin
                px.word <= expanded;
                px.col <= px.col + 10'h001;
            end
            if (hs_fall) begin
                px.col <= 10'h000;
                if (px.col != 10'h000) begin
                    px.row <= px.row + 10'h001;
                end
            end
            if (vs_fall) begin
                px.row <= 10'h000;
            end
        end
    end

    wf_col_a: assert property (@(posedge clk) disable iff (!rst_n)
        take && !hs_fall |=> px.col == $past(px.col) + 10'h001)
        else $error("column did not advance on captured word");
endmodule
`default_nettype wire

/* File: src/panel_rgb_input.sv */
/*
 * Parallel RGB video input and hardware reset handling of the panel.
 * Assumes the host keeps line and frame timing; pins are asynchronous.
 */
// Notes on behaviour
// - Capture 24/18/16-bit pixel words on pixel clock while qualifier high.
// - Ignore reset lows under 5 us, reset on over 9 us; host holds 10 us.
// - Short releases during a valid reset do not end it early.
// - After reset release reload ids, common voltage from storage; words 2 and 3 are read, not kept.
// - Blank display during reset, defaults restored while in reset.
// - Reset-cancel at most 5 ms from sleep, 120 ms from awake.
`timescale 1ns/1ps
`default_nettype none
module panel_rgb_input
    import panel_pkg::*;
#(
    parameter int SPIKE_CYC = SPIKE_REJECT_CYC,
    parameter int SURE_CYC = RESET_SURE_CYC,
    parameter int SLEEP_CANCEL_CYC = CANCEL_SLEEP_CYC,
    parameter int AWAKE_CANCEL_CYC = CANCEL_AWAKE_CYC,
    parameter int CNT_W = 26
) (
    // Core clock and reset
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    // Host video pins
    input wire logic PIXEL_CLK,
    input wire logic HORIZONTAL_SYNC,
    input wire logic VERTICAL_SYNC,
    input wire logic PIXEL_VALID_QUALIFIER,
    input wire logic [23:0] PIXEL_BUS,
    input wire logic [1:0] BUS_FORMAT,
    // Reset pin and mode
    input wire logic HARDWARE_RESET_PIN_N,
    input wire logic SLEEP_MODE,
    // Nonvolatile storage reload
    output logic NVM_READ,
    output logic [1:0] NVM_ADDR,
    input wire logic [7:0] NVM_DATA,
    // Results
    output logic PANEL_RESET,
    output logic DISPLAY_BLANK,
    output logic READY,
    output logic [7:0] ID_BYTE,
    output logic [7:0] COMMON_VOLTAGE_SETTING,
    output logic PIXEL_WORD_VALID,
    output logic [23:0] PIXEL_WORD,
    output logic [9:0] PIXEL_COL,
    output logic [9:0] PIXEL_ROW
);
    logic [1:0] pclk_s_q, hs_s_q, vs_s_q, de_s_q, rst_s_q, slp_s_q;
    logic [23:0] db_s1_q, db_s2_q;
    logic [1:0] fmt_s1_q, fmt_s2_q;
    logic pclk_last_q;
    logic [CNT_W-1:0] low_cnt_q, high_cnt_q, cancel_cnt_q, cancel_lim_q;
    logic [2:0] load_idx_q;
    reset_state_type state_q, state_d;
    pixel_if px();

    wire pin_low = !rst_s_q[1];
    wire low_long = low_cnt_q >= CNT_W'(SPIKE_CYC);
    wire low_sure = low_cnt_q >= CNT_W'(SURE_CYC);
    wire high_long = high_cnt_q >= CNT_W'(SPIKE_CYC);
    wire cancel_done = cancel_cnt_q >= cancel_lim_q;
    wire loading = state_q == RST_CANCEL && load_idx_q < 3'(RELOAD_WORDS);

    // Pins cross into the core clock through two flops each
    always_ff @(posedge CORE_CLK) begin
        pclk_s_q <= {pclk_s_q[0], PIXEL_CLK};
        hs_s_q <= {hs_s_q[0], HORIZONTAL_SYNC};
        vs_s_q <= {vs_s_q[0], VERTICAL_SYNC};
        de_s_q <= {de_s_q[0], PIXEL_VALID_QUALIFIER};
        rst_s_q <= {rst_s_q[0], HARDWARE_RESET_PIN_N};
        slp_s_q <= {slp_s_q[0], SLEEP_MODE};
        db_s1_q <= PIXEL_BUS;
        db_s2_q <= db_s1_q;
        fmt_s1_q <= BUS_FORMAT;
        fmt_s2_q <= fmt_s1_q;
        pclk_last_q <= pclk_s_q[1];
    end

    // Low and high run lengths of the synchronised reset pin
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N || !pin_low) begin
            low_cnt_q <= '0;
        end else if (!low_sure) begin
            low_cnt_q <= low_cnt_q + CNT_W'(1);
        end
        if (!RESET_N || pin_low) begin
            high_cnt_q <= '0;
        end else if (!high_long) begin
            high_cnt_q <= high_cnt_q + CNT_W'(1);
        end
    end

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            RST_IDLE: begin
                if (low_long) state_d = RST_PENDING;
            end
            RST_PENDING: begin
                // A reset that has started runs to completion
                if (low_sure || !pin_low) state_d = RST_ACTIVE;
            end
            RST_ACTIVE: begin
                // Only a release outlasting the spike window ends reset
                if (high_long) state_d = RST_CANCEL;
            end
            RST_CANCEL: begin
                if (low_long) state_d = RST_PENDING;
                else if (cancel_done && !loading) state_d = RST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            state_q <= RST_IDLE;
            cancel_cnt_q <= '0;
            cancel_lim_q <= CNT_W'(SLEEP_CANCEL_CYC);
        end else begin
            state_q <= state_d;
            if (state_q == RST_IDLE && low_long) begin
                cancel_lim_q <= slp_s_q[1] ? CNT_W'(SLEEP_CANCEL_CYC)
                    : CNT_W'(AWAKE_CANCEL_CYC);
            end
            if (state_q == RST_CANCEL && !cancel_done) begin
                cancel_cnt_q <= cancel_cnt_q + CNT_W'(1);
            end else if (state_q != RST_CANCEL) begin
                // The limit runs from the pin's rise, not from cancel entry
                cancel_cnt_q <= CNT_W'(SPIKE_CYC + CANCEL_LAG_CYC);
            end
        end
    end

    // Reload walks the storage words; read data is taken in the same cycle as NVM_READ and NVM_ADDR
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N || state_q != RST_CANCEL) begin
            load_idx_q <= 3'h0;
            NVM_READ <= 1'b0;
            NVM_ADDR <= 2'h0;
        end else begin
            NVM_READ <= loading;
            NVM_ADDR <= load_idx_q[1:0];
            if (loading) load_idx_q <= load_idx_q + 3'h1;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N || state_q == RST_ACTIVE) begin
            ID_BYTE <= ID_BYTE_RESET;
            COMMON_VOLTAGE_SETTING <= COMMON_VOLTAGE_SETTING_RESET;
        end else if (NVM_READ && NVM_ADDR == 2'h0) begin
            ID_BYTE <= NVM_DATA;
        end else if (NVM_READ && NVM_ADDR == 2'h1) begin
            COMMON_VOLTAGE_SETTING <= NVM_DATA;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            PANEL_RESET <= 1'b0;
            DISPLAY_BLANK <= 1'b1;
            READY <= 1'b0;
        end else begin
            PANEL_RESET <= state_q == RST_PENDING || state_q == RST_ACTIVE;
            DISPLAY_BLANK <= state_q != RST_IDLE;
            READY <= state_q == RST_IDLE;
        end
    end

    assign px.pclk_rise = pclk_s_q[1] && !pclk_last_q;
    assign px.hsync = hs_s_q[1];
    assign px.vsync = vs_s_q[1];
    assign px.qualifier = de_s_q[1];
    assign px.data = db_s2_q;
    assign px.fmt = fmt_s2_q;
    assign px.blank = DISPLAY_BLANK;

    pixel_capture capture (
        .clk(CORE_CLK),
        .rst_n(RESET_N),
        .px(px.cap)
    );

    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            PIXEL_WORD_VALID <= 1'b0;
            PIXEL_WORD <= 24'h000000;
            PIXEL_COL <= 10'h000;
            PIXEL_ROW <= 10'h000;
        end else begin
            PIXEL_WORD_VALID <= px.word_valid;
            PIXEL_WORD <= px.word;
            PIXEL_COL <= px.col;
            PIXEL_ROW <= px.row;
        end
    end

    spike_reject_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        state_q == RST_IDLE && !low_long
        |=> state_q == RST_IDLE && !PANEL_RESET)
        else $error("reset started on a short spike");
    reset_sure_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        state_q == RST_PENDING && low_sure |=> state_q == RST_ACTIVE)
        else $error("long reset pulse not taken");
    hold_reset_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        state_q == RST_ACTIVE && !high_long |=> state_q == RST_ACTIVE)
        else $error("reset ended on a short release");
    blank_out_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        state_q == RST_ACTIVE |=> DISPLAY_BLANK && PANEL_RESET)
        else $error("display not blanked in reset");
    default_load_a: assert property (@(posedge CORE_CLK)
        disable iff (!RESET_N)
        state_q == RST_ACTIVE |=> ID_BYTE == ID_BYTE_RESET)
        else $error("defaults not restored in reset");
    reload_start_a: assert property (@(posedge CORE_CLK)
        disable iff (!RESET_N)
        $rose(state_q == RST_CANCEL) |=> NVM_READ && NVM_ADDR == 2'h0)
        else $error("storage reload did not start");
    cancel_bound_a: assert property (@(posedge CORE_CLK)
        disable iff (!RESET_N)
        state_q == RST_CANCEL && cancel_done && !loading && !low_long
        |=> READY == 1'b0 ##1 READY)
        else $error("reset cancel overran its limit");
endmodule
`default_nettype wire

/* File: sim/host_video_model.sv */
/*
 * Behavioural host display controller: pixel clock, syncs, qualifier, bus.
 * Assumes the bench calls line() once per video line, one after another.
 */
`timescale 1ns/1ps
`default_nettype none
module host_video_model #(
    parameter int H_ACT = 480
) (
    // Video pins
    output logic pclk,
    output logic hsync_n,
    output logic vsync_n,
    output logic qualifier,
    output logic [23:0] pixels
);
    initial begin
        pclk = 1'b0;
        hsync_n = 1'b1;
        vsync_n = 1'b1;
        qualifier = 1'b0;
        pixels = 24'h000000;
    end

    // A released bus toggles so that no stale word looks valid
    task automatic tick(input logic hs, input logic de, input logic [23:0] px);
        pixels = de ? px : ~pixels;
        qualifier = de;
        hsync_n = hs;
        #62.5 pclk = 1'b1;
        #62.5 pclk = 1'b0;
    endtask

    // Clock stands low once the line ends
    task automatic line(input logic vs, input logic act, input logic [23:0] px);
        vsync_n = vs;
        tick(1'b0, 1'b0, px);
        repeat (2) tick(1'b1, 1'b0, px);
        repeat (H_ACT) tick(1'b1, act, px);
        repeat (2) tick(1'b1, 1'b0, px);
    endtask
endmodule
`default_nettype wire

/* File: sim/tb_top.sv */
/*
 * Self-checking bench for panel_rgb_input: capture table, reset pin
 * filtering, settings reload and cancel timing.
 * Assumes host_video_model on the video pins and short filter counts.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import panel_pkg::*;
;
    // Short lines keep the run brief; capture has no fixed line length
    localparam int HA = 48;
    typedef struct {logic [1:0] f; logic [23:0] d; logic [23:0] e;} row_type;
    row_type rows [4] = '{'{FMT_24, 24'ha5c3f0, 24'ha5c3f0},
        '{FMT_18, 24'h03ffff, 24'hffffff}, '{FMT_18, 24'h020820, 24'h828282},
        '{FMT_16, 24'h008410, 24'h848284}};
    int lows [2] = '{10, 28};
    logic clk = 1'b0, rst_n = 1'b0, pin_n = 1'b1, sleep = 1'b0;
    logic [1:0] fmt = 2'h0;
    wire logic pclk, hs_n, vs_n, de;
    wire logic [23:0] bus;
    logic rd, prst, blank, rdy, wv;
    logic [1:0] addr;
    logic [7:0] idb, common_voltage_setting, nvm_data;
    logic [23:0] word, exp_word;
    logic [9:0] col, row;
    logic [7:0] nvm [4] = '{8'h3c, 8'h5a, 8'h77, 8'h99};
    int n_mismatch = 0, checks_done = 0, n_words = 0, n_rd = 0, n = 0;
    bit seen_rst = 0, chk_words = 0;

    always #2 clk = ~clk;
    assign nvm_data = nvm[addr];

    host_video_model #(.H_ACT(HA)) u_host_video_model (.pclk(pclk),
        .hsync_n(hs_n), .vsync_n(vs_n), .qualifier(de), .pixels(bus));

    panel_rgb_input #(.SPIKE_CYC(20), .SURE_CYC(36), .SLEEP_CANCEL_CYC(200),
        .AWAKE_CANCEL_CYC(400)) u_panel_rgb_input (.CORE_CLK(clk),
        .RESET_N(rst_n), .PIXEL_CLK(pclk), .HORIZONTAL_SYNC(hs_n),
        .VERTICAL_SYNC(vs_n), .PIXEL_VALID_QUALIFIER(de), .PIXEL_BUS(bus),
        .BUS_FORMAT(fmt), .HARDWARE_RESET_PIN_N(pin_n), .SLEEP_MODE(sleep),
        .NVM_READ(rd), .NVM_ADDR(addr), .NVM_DATA(nvm_data),
        .PANEL_RESET(prst), .DISPLAY_BLANK(blank), .READY(rdy),
        .ID_BYTE(idb), .COMMON_VOLTAGE_SETTING(common_voltage_setting),
        .PIXEL_WORD_VALID(wv), .PIXEL_WORD(word), .PIXEL_COL(col),
        .PIXEL_ROW(row));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("checks=%0d mismatches=%0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic wait_ready();
        n = 0;
        while (rdy !== 1'b1 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        check(rdy, 1'b1);
    endtask

    // Outputs are registered, so the falling edge sees them settled
    always @(negedge clk) begin
        if (prst === 1'b1) seen_rst = 1'b1;
        if (rd === 1'b1) n_rd++;
        if (wv === 1'b1) begin
            n_words++;
            if (chk_words) check(word, exp_word);
        end
    end

    initial begin
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        check(blank, 1'b0);
        check(rdy, 1'b1);
        check(idb, ID_BYTE_RESET);
        check(common_voltage_setting, COMMON_VOLTAGE_SETTING_RESET);
        $display("test core reset done");
        chk_words = 1;
        u_host_video_model.line(1'b0, 1'b0, 24'h0);
        u_host_video_model.line(1'b1, 1'b0, 24'h0);
        foreach (rows[i]) begin
            @(negedge clk) fmt = rows[i].f;
            exp_word = rows[i].e;
            n_words = 0;
            u_host_video_model.line(1'b1, 1'b1, rows[i].d);
            repeat (8) @(negedge clk);
            check(n_words, HA);
            check(col, HA);
            check(row, i);
            $display("test row %0d done", i);
        end
        u_host_video_model.line(1'b1, 1'b0, 24'h0);
        chk_words = 0;
        foreach (lows[j]) begin
            seen_rst = 0;
            @(negedge clk) pin_n = 1'b0;
            repeat (lows[j]) @(negedge clk);
            pin_n = 1'b1;
            repeat (40) @(negedge clk);
            check(seen_rst, j > 0);
            wait_ready();
            $display("test pulse %0d done", lows[j]);
        end
        // Sleeping reset with a short release inside it
        sleep = 1'b1;
        n_rd = 0;
        @(negedge clk) pin_n = 1'b0;
        repeat (40) @(negedge clk);
        pin_n = 1'b1;
        repeat (8) @(negedge clk);
        pin_n = 1'b0;
        repeat (30) @(negedge clk);
        check(n_rd, 0);
        check(prst, 1'b1);
        check(blank, 1'b1);
        check(idb, ID_BYTE_RESET);
        pin_n = 1'b1;
        wait_ready();
        check(n >= 190 && n <= 200, 1'b1);
        check(n_rd, 4);
        check(idb, 8'h3c);
        check(common_voltage_setting, 8'h5a);
        check(blank, 1'b0);
        $display("test sleep reset done");
        // Awake reset: words sent while blanked must be dropped
        sleep = 1'b0;
        @(negedge clk) pin_n = 1'b0;
        repeat (40) @(negedge clk);
        n_words = 0;
        u_host_video_model.line(1'b1, 1'b1, 24'h123456);
        check(n_words, 0);
        @(negedge clk) pin_n = 1'b1;
        wait_ready();
        check(n >= 390 && n <= 400, 1'b1);
        check(n_rd, 8);
        $display("test awake reset done");
        summarize();
    end

    // About five times the expected run of roughly 60 us
    initial begin
        #300000;
        n_mismatch++;
        summarize();
    end
endmodule
`default_nettype wire
